/* File: verilog/hscx_ctrl.v */
`timescale 1ns/1ns
`default_nettype none
`include "hscx_regs.vh"

module hscx_ctrl #(
	parameter [19:0] CHIRP_K_CYC   = `HSCX_CHIRP_K_CYC,
	parameter [19:0] HOST_WAIT_CYC = `HSCX_HOST_WAIT_CYC,
	parameter [7:0]  FILT_CYC      = `HSCX_FILT_CYC
) (
	input  wire        pclk,
	input  wire        presetn,
	input  wire [11:0] paddr,
	input  wire        psel,
	input  wire        penable,
	input  wire        pwrite,
	input  wire [31:0] pwdata,
	output reg  [31:0] prdata,
	output wire        pready,
	output wire        pslverr,
	input  wire        clkout,
	input  wire [1:0]  linestate,
	output reg  [1:0]  xcvrselect,
	output reg         termselect,
	output reg  [1:0]  opmode,
	output reg         txvalid,
	output reg  [7:0]  data_out,
	output wire        suspendn
);

	// ==========================================
	// States
	localparam [2:0] ST_IDLE   = 3'd0;
	localparam [2:0] ST_SUSP   = 3'd1;
	localparam [2:0] ST_WCLK   = 3'd2;
	localparam [2:0] ST_CHIRP  = 3'd3;
	localparam [2:0] ST_LISTEN = 3'd4;
	localparam [2:0] ST_HS     = 3'd5;
	localparam [2:0] ST_FS     = 3'd6;

	localparam [2:0] KJ_PAIRS = `HSCX_KJ_PAIRS;

	// Only the SLEEP bit of the reset word loads a register; start_req resets to 0.
	localparam [31:0] CTRL_RST = `HSCX_CTRL_RST;

	reg  [2:0]  state;
	reg  [19:0] cyc;
	reg  [2:0]  chirp_cnt;
	reg         expect_k;
	reg         hs_mode;
	reg         fs_fallback;
	reg         susp_n;
	reg         start_req;
	reg         sleep_req;

	reg  [1:0]  ls_m;
	reg  [1:0]  ls_s;
	reg  [1:0]  ls_prev;
	reg         ck_m;
	reg         ck_s;
	reg         ck_d;

	wire        tick;
	wire        wake;
	wire        dv;
	wire [1:0]  dv_state;
	wire        filt_en;

	// ==========================================
	// Input synchronisers
	// The transceiver clock is sampled like any pin; its rising edges
	// become one-cycle ticks that pace every protocol timer.
	always @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			ls_m    <= `HSCX_LS_SE0;
			ls_s    <= `HSCX_LS_SE0;
			ls_prev <= `HSCX_LS_SE0;
			ck_m    <= 1'b0;
			ck_s    <= 1'b0;
			ck_d    <= 1'b0;
		end
		else
		begin
			ls_m    <= linestate;
			ls_s    <= ls_m;
			ls_prev <= ls_s;
			ck_m    <= clkout;
			ck_s    <= ck_m;
			ck_d    <= ck_s;
		end
	end

	assign tick = ck_s & ~ck_d;

	// ==========================================
	// Suspend release
	// J to SE0 wakes
	assign wake = (state == ST_SUSP) &&
	              (ls_prev == `HSCX_LS_J) &&
	              (ls_s == `HSCX_LS_SE0);

	// The release is combinational so the transceiver oscillator starts
	// as early as possible; its start-up eats most of the chirp budget.
	assign suspendn = susp_n | wake;

	// ==========================================
	// APB slave
	wire        wr_en;
	wire        rd_setup;
	wire        hit_ctrl;
	wire        hit_stat;
	wire [31:0] ctrl_val;
	wire [31:0] stat_val;

	assign hit_ctrl = (paddr == `HSCX_CTRL_OFS);
	assign hit_stat = (paddr == `HSCX_STAT_OFS);
	assign wr_en    = psel & penable & pwrite & hit_ctrl;
	assign rd_setup = psel & ~penable & ~pwrite;
	assign pready   = 1'b1;
	assign pslverr  = psel & penable & ~hit_ctrl & ~(hit_stat & ~pwrite);

	assign ctrl_val = {30'h0000_0000, sleep_req, 1'b0};

	assign stat_val = {21'h00_0000, chirp_cnt, 2'h0, fs_fallback,
	                   hs_mode, 1'b0, state};

	always @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			start_req <= 1'b0;
			sleep_req <= CTRL_RST[`HSCX_CTRL_SLEEP];
			prdata    <= 32'h0000_0000;
		end
		else
		begin
			start_req <= wr_en & pwdata[`HSCX_CTRL_START];
			if (wr_en)
				sleep_req <= pwdata[`HSCX_CTRL_SLEEP];
			if (rd_setup)
			begin
				if (hit_ctrl)
					prdata <= ctrl_val;
				else if (hit_stat)
					prdata <= stat_val;
				else
					prdata <= 32'h0000_0000;
			end
		end
	end

	// ==========================================
	// Host chirp filter
	assign filt_en = (state == ST_LISTEN);

	hscx_filt #(
		.FILT_CYC (FILT_CYC)
	) u_filt (
		.pclk    (pclk),
		.presetn (presetn),
		.en      (filt_en),
		.tick    (tick),
		.ls      (ls_s),
		.valid   (dv),
		.state   (dv_state)
	);

	// ==========================================
	// Handshake sequencer
	// Software starts the handshake at entry, or a J to SE0 wake from suspend does; it must do so early enough
	// that the fixed chirp length still ends inside the reset window.
	always @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			state       <= ST_IDLE;
			cyc         <= 20'h0_0000;
			chirp_cnt   <= 3'h0;
			expect_k    <= 1'b1;
			hs_mode     <= 1'b0;
			fs_fallback <= 1'b0;
			susp_n      <= 1'b1;
			xcvrselect  <= `HSCX_XCVR_FS;
			termselect  <= `HSCX_TERM_FS;
			opmode      <= `HSCX_OPM_NORMAL;
			txvalid     <= 1'b0;
			data_out    <= `HSCX_CHIRP_DATA;
		end
		else
		begin
			case (state)
			ST_IDLE, ST_HS, ST_FS:
			begin
				if (start_req)
				begin
					state       <= ST_CHIRP;
					cyc         <= 20'h0_0000;
					hs_mode     <= 1'b0;
					fs_fallback <= 1'b0;
					xcvrselect  <= `HSCX_XCVR_HS;
					termselect  <= `HSCX_TERM_FS;
					opmode      <= `HSCX_OPM_NOSTUFF;
					txvalid     <= 1'b1;
					data_out    <= `HSCX_CHIRP_DATA;
				end
				else if (sleep_req)
				begin
					state       <= ST_SUSP;
					hs_mode     <= 1'b0;
					fs_fallback <= 1'b0;
					xcvrselect  <= `HSCX_XCVR_FS;
					termselect  <= `HSCX_TERM_FS;
					opmode      <= `HSCX_OPM_NORMAL;
					txvalid     <= 1'b0;
					susp_n      <= 1'b0;
				end
			end
			ST_SUSP:
			begin
				if (wake)
				begin
					state  <= ST_WCLK;
					susp_n <= 1'b1;
				end
				else if (!sleep_req)
				begin
					state  <= ST_IDLE;
					susp_n <= 1'b1;
				end
			end
			ST_WCLK:
			begin
				if (tick)
				begin
					state      <= ST_CHIRP;
					cyc        <= 20'h0_0000;
					xcvrselect <= `HSCX_XCVR_HS;
					termselect <= `HSCX_TERM_FS;
					opmode     <= `HSCX_OPM_NOSTUFF;
					txvalid    <= 1'b1;
					data_out   <= `HSCX_CHIRP_DATA;
				end
			end
			ST_CHIRP:
			begin
				if (tick)
				begin
					if (cyc == CHIRP_K_CYC - 20'h0_0001)
					begin
						state     <= ST_LISTEN;
						cyc       <= 20'h0_0000;
						txvalid   <= 1'b0;
						opmode    <= `HSCX_OPM_NORMAL;
						chirp_cnt <= 3'h0;
						expect_k  <= 1'b1;
					end
					else
						cyc <= cyc + 20'h0_0001;
				end
			end
			ST_LISTEN:
			begin
				if (chirp_cnt == KJ_PAIRS)
				begin
					state      <= ST_HS;
					termselect <= `HSCX_TERM_HS;
					hs_mode    <= 1'b1;
				end
				else if (tick && cyc == HOST_WAIT_CYC - 20'h0_0001)
				begin
					state       <= ST_FS;
					xcvrselect  <= `HSCX_XCVR_FS;
					fs_fallback <= 1'b1;
				end
				else
				begin
					if (tick)
						cyc <= cyc + 20'h0_0001;
					if (dv)
					begin
						if (dv_state == (expect_k ? `HSCX_LS_K : `HSCX_LS_J))
						begin
							chirp_cnt <= chirp_cnt + 3'h1;
							expect_k  <= ~expect_k;
						end
						else
						begin
							chirp_cnt <= 3'h0;
							expect_k  <= 1'b1;
						end
					end
				end
			end
			default:
			begin
				state <= ST_IDLE;
			end
			endcase
		end
	end

endmodule // hscx_ctrl
`default_nettype wire

/* File: common/hscx_regs.vh */
`ifndef HSCX_REGS_VH
`define HSCX_REGS_VH

// ==========================================
// Register map (APB, one word each)
`define HSCX_CTRL_OFS      12'h000
`define HSCX_STAT_OFS      12'h004
`define HSCX_CTRL_RST      32'h0000_0000
`define HSCX_CTRL_START    0
`define HSCX_CTRL_SLEEP    1
`define HSCX_STAT_STATE_LO 0
`define HSCX_STAT_STATE_HI 2
`define HSCX_STAT_HS       4
`define HSCX_STAT_FS       5
`define HSCX_STAT_CNT_LO   8
`define HSCX_STAT_CNT_HI   10

// ==========================================
// Transceiver codes
`define HSCX_LS_SE0        2'h0
`define HSCX_LS_J          2'h1
`define HSCX_LS_K          2'h2
`define HSCX_XCVR_HS       2'h0
`define HSCX_XCVR_FS       2'h1
`define HSCX_TERM_HS       1'b0
`define HSCX_TERM_FS       1'b1
`define HSCX_OPM_NORMAL    2'h0
`define HSCX_OPM_NOSTUFF   2'h2
`define HSCX_CHIRP_DATA    8'h00

// ==========================================
// Timing; the CYC values are counted in transceiver clock cycles
`define HSCX_CLKOUT_MHZ    60
`define HSCX_FILT_NS       2500
`define HSCX_FILT_CYC      165
`define HSCX_CHIRP_K_CYC   66000
`define HSCX_HOST_WAIT_US  2000
`define HSCX_HOST_WAIT_CYC (`HSCX_HOST_WAIT_US * `HSCX_CLKOUT_MHZ)
`define HSCX_KJ_PAIRS      3'h6

`endif

/* File: verilog/hscx_filt.v */
`timescale 1ns/1ns
`default_nettype none
`include "hscx_regs.vh"

module hscx_filt #(
	parameter [7:0] FILT_CYC = `HSCX_FILT_CYC
) (
	input  wire       pclk,
	input  wire       presetn,
	input  wire       en,
	input  wire       tick,
	input  wire [1:0] ls,
	output reg        valid,
	output reg  [1:0] state
);

	reg [1:0] last;
	reg [7:0] cnt;
	reg       done;

	// ==========================================
	// Line state debounce
	always @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			last  <= `HSCX_LS_SE0;
			cnt   <= 8'h00;
			done  <= 1'b0;
			valid <= 1'b0;
			state <= `HSCX_LS_SE0;
		end
		else
		begin
			valid <= 1'b0;
			if (!en)
			begin
				last <= ls;
				cnt  <= 8'h00;
				done <= 1'b0;
			end
			else if (ls != last)
			begin
				last <= ls;
				cnt  <= 8'h00;
				done <= 1'b0;
			end
			else if (tick && !done)
			begin
				if (cnt == FILT_CYC - 8'h01)
				begin
					valid <= 1'b1;
					state <= last;
					done  <= 1'b1;
				end
				else
					cnt <= cnt + 8'h01;
			end
		end
	end

endmodule // hscx_filt
`default_nettype wire

/* File: testbench/hscx_ctrl_asserts.sv */
`timescale 1ns/1ns
`default_nettype none
module hscx_ctrl_asserts #(
	parameter [19:0] CHIRP_K_CYC = 20'h1_01D0
) (
	input wire logic       pclk,
	input wire logic       presetn,
	input wire logic       clkout,
	input wire logic [1:0] linestate,
	input wire logic [1:0] xcvrselect,
	input wire logic       termselect,
	input wire logic [1:0] opmode,
	input wire logic       txvalid,
	input wire logic [7:0] data_out,
	input wire logic       suspendn
);
	logic        ck_d;
	logic [19:0] tick_cnt;
	// Raw clock edges are counted without the design's synchroniser, hence the one-edge slack below.
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			ck_d     <= 1'b0;
			tick_cnt <= 20'h0_0000;
		end
		else
		begin
			ck_d     <= clkout;
			tick_cnt <= !txvalid ? 20'h0_0000 : tick_cnt + {19'h0_0000, clkout & ~ck_d};
		end
	end
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);
	property p_chirp_mode;
		txvalid |-> opmode == 2'h2 && xcvrselect == 2'h0;
	endproperty
	a_chirp_mode: assert property (p_chirp_mode) else $error("chirp outside no-stuff HS mode");
	property p_chirp_data;
		txvalid |-> data_out == 8'h00 && termselect;
	endproperty
	a_chirp_data: assert property (p_chirp_data) else $error("chirp data not zero");
	property p_chirp_end;
		$fell(txvalid) |-> opmode == 2'h0 && xcvrselect == 2'h0;
	endproperty
	a_chirp_end: assert property (p_chirp_end) else $error("chirp end left wrong mode");
	property p_chirp_len;
		$fell(txvalid) |-> tick_cnt >= CHIRP_K_CYC - 20'h0_0001 && tick_cnt <= CHIRP_K_CYC + 20'h0_0001;
	endproperty
	a_chirp_len: assert property (p_chirp_len) else $error("chirp length wrong");
	property p_hs_term;
		$fell(termselect) |-> xcvrselect == 2'h0 && !txvalid && $past(linestate, 3) == 2'h1;
	endproperty
	a_hs_term: assert property (p_hs_term) else $error("HS terminations without host pattern");
	property p_fs_back;
		$rose(xcvrselect[0]) |-> termselect && !txvalid;
	endproperty
	a_fs_back: assert property (p_fs_back) else $error("fallback with wrong terminations");
	property p_wake;
		!suspendn && $past(linestate) == 2'h1 && linestate == 2'h0 |-> ##[1:5] suspendn;
	endproperty
	a_wake: assert property (p_wake) else $error("no wake on J to SE0");
	property p_awake_chirp;
		$rose(txvalid) |-> suspendn;
	endproperty
	a_awake_chirp: assert property (p_awake_chirp) else $error("chirp while suspended");
endmodule // hscx_ctrl_asserts
bind hscx_ctrl hscx_ctrl_asserts #(.CHIRP_K_CYC(CHIRP_K_CYC)) i_chk (.pclk(pclk), .presetn(presetn),
	.clkout(clkout), .linestate(linestate), .xcvrselect(xcvrselect), .termselect(termselect),
	.opmode(opmode), .txvalid(txvalid), .data_out(data_out), .suspendn(suspendn));
`default_nettype wire

/* File: testbench/hscx_xcvr_model.sv */
`timescale 1ns/1ns
`default_nettype none
module hscx_xcvr_model #(
	parameter int WAKE_NS = 2003
) (
	input wire logic        suspendn,
	input wire logic        txvalid,
	input wire logic [1:0]  host_ls,
	output var logic        clkout,
	output wire logic [1:0] linestate
);
	assign linestate = txvalid ? 2'h2 : host_ls;
	initial clkout = 1'b0;
	always
	begin
		wait (suspendn === 1'b1);
		#WAKE_NS;
		while (suspendn === 1'b1)
			#40 clkout = ~clkout;
		clkout = 1'b0;
	end
endmodule // hscx_xcvr_model
`default_nettype wire

/* File: testbench/hs_chirp_handshake_tb.sv */
`timescale 1ns/1ns
`default_nettype none
`include "hscx_regs.vh"
module hs_chirp_handshake_tb;
	logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, clkout, termselect, txvalid;
	logic        suspendn, fs_sel, er;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, rd;
	logic [1:0]  linestate, xcvrselect, opmode, host_ls;
	logic [7:0]  data_out;
	int          err_total, checks_done;
	always_comb fs_sel = xcvrselect[0];
	hscx_ctrl #(.CHIRP_K_CYC(20'h0_00C8), .HOST_WAIT_CYC(20'h0_07D0), .FILT_CYC(8'h08)) i_dut (.pclk,
		.presetn, .paddr, .psel, .penable, .pwrite, .pwdata, .prdata, .pready, .pslverr, .clkout,
		.linestate, .xcvrselect, .termselect, .opmode, .txvalid, .data_out, .suspendn);
	hscx_xcvr_model i_xcvr (.suspendn, .txvalid, .host_ls, .clkout, .linestate);
	initial
	begin
		pclk = 1'b0;
		forever #5 pclk = ~pclk;
	end
	task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
		checks_done++;
		if (seen !== exp)
		begin
			err_total++;
			$display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
		end
	endtask
	task automatic complete_run;
		$display("comparisons %0d mismatches %0d", checks_done, err_total);
		if (err_total == 0 && checks_done > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask
	task automatic await(input string what, ref logic s, input logic v, input int lim);
		for (int i = 0; i < lim && s !== v; i++)
			@(posedge pclk);
		check(what, 32'(s), 32'(v));
		if (s !== v)
			complete_run;
	endtask
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		@(posedge pclk);
		{psel, penable, pwrite, paddr, pwdata} <= {1'b1, 1'b0, w, a, d};
		@(posedge pclk);
		penable <= 1'b1;
		@(posedge pclk);
		for (int i = 0; i < 16 && pready !== 1'b1; i++)
			@(posedge pclk);
		if (pready !== 1'b1)
			await("pready", pready, 1'b1, 0);
		rd = prdata;
		er = pslverr;
		{psel, penable} <= 2'b00;
	endtask
	task automatic s_reset;
		check("pins", 32'({xcvrselect, termselect, opmode, txvalid, data_out, suspendn}), 32'h0000_3001);
		apb(1'b0, `HSCX_CTRL_OFS, 32'h0000_0000);
		check("ctrl", rd, `HSCX_CTRL_RST);
		apb(1'b0, 12'h008, 32'h0000_0000);
		check("unmapped", 32'(er), 32'h0000_0001);
		apb(1'b1, `HSCX_STAT_OFS, 32'h0000_0001);
		check("ro status", 32'(er), 32'h0000_0001);
	endtask
	task automatic s_fs;
		apb(1'b1, `HSCX_CTRL_OFS, 32'h0000_0001);
		await("chirp on", txvalid, 1'b1, 20);
		check("chirp", 32'({xcvrselect, opmode, data_out}), 32'h0000_0200);
		await("chirp off", txvalid, 1'b0, 2000);
		check("opmode", 32'(opmode), 32'h0000_0000);
		repeat (15500) @(posedge pclk);
		check("early fs", 32'(fs_sel), 32'h0000_0000);
		await("fs", fs_sel, 1'b1, 1000);
		apb(1'b0, `HSCX_STAT_OFS, 32'h0000_0000);
		check("fs stat", rd & 32'h0000_0027, 32'h0000_0026);
	endtask
	task automatic s_hs;
		apb(1'b1, `HSCX_CTRL_OFS, 32'h0000_0001);
		await("chirp on", txvalid, 1'b1, 20);
		await("chirp off", txvalid, 1'b0, 2000);
		host_ls <= `HSCX_LS_J;
		repeat (30) @(posedge pclk);
		for (int i = 0; i < 6; i++)
		begin
			check("term", 32'(termselect), 32'h0000_0001);
			host_ls <= i[0] ? `HSCX_LS_J : `HSCX_LS_K;
			repeat (160) @(posedge pclk);
		end
		check("hs term", 32'(termselect), 32'h0000_0000);
		host_ls <= `HSCX_LS_SE0;
		apb(1'b0, `HSCX_STAT_OFS, 32'h0000_0000);
		check("hs stat", rd & 32'h0000_071F, 32'h0000_0615);
	endtask
	task automatic s_susp;
		presetn <= 1'b0;
		repeat (2) @(posedge pclk);
		presetn <= 1'b1;
		apb(1'b1, `HSCX_CTRL_OFS, 32'h0000_0002);
		apb(1'b0, `HSCX_STAT_OFS, 32'h0000_0000);
		check("susp", 32'({suspendn, rd[2:0]}), 32'h0000_0001);
		host_ls <= `HSCX_LS_J;
		repeat (10) @(posedge pclk);
		host_ls <= `HSCX_LS_SE0;
		await("wake", suspendn, 1'b1, 8);
		check("no clock chirp", 32'(txvalid), 32'h0000_0000);
		await("wake chirp", txvalid, 1'b1, 400);
	endtask
	initial
	begin
		{presetn, psel, penable, pwrite, paddr, pwdata} = '0;
		host_ls = `HSCX_LS_SE0;
		err_total = 0;
		checks_done = 0;
		repeat (8) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		s_reset;
		s_fs;
		s_hs;
		s_susp;
		complete_run;
	end
endmodule // hs_chirp_handshake_tb
`default_nettype wire
